// ### logic/color_result_status_readout.sv
// Overview of operation
// (R1) status register at 0x13 is read-only; writes there change nothing.
// (R2) status bit 4 reads one while the clear-channel threshold interrupt is pending.
// (R3) status bit 0 reads one once all four channels finished an integration; bits other than 0 and 4 zero.
// (R4) the clear interrupt is raised when clear falls below low or rises above high threshold.
// (R5) each of clear, red, green, blue is a 16-bit unsigned value shown as low and high byte.
// (R6) result bytes sit low then high from 0x14 (clear) up to 0x1b (blue high).
// (R7) reading a low byte copies that channel's upper eight bits into a shadow at that moment.
// (R8) a later read of the matching high byte returns the shadow, not the live byte.
// (R9) the shadow keeps its value across further integrations until the next low-byte read.
// (R10) the host should fetch each result as one two-byte word read starting at the low byte.
module color_result_status_readout
	import color_readout_pkg::*;
(
	input  wire logic                                 clock,
	input  wire logic                                 sys_rst,
	// register port
	input  wire logic                                 reg_rd,
	input  wire logic                                 reg_wr,
	input  wire logic [color_readout_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [color_readout_pkg::DATA_W-1:0] reg_wdata,
	output logic      [color_readout_pkg::DATA_W-1:0] reg_rdata,
	output logic                                      reg_rvalid,
	// conversion engine side
	input  wire logic                                 integration_end,
	input  wire logic [color_readout_pkg::RESULT_W-1:0] clear_value,
	input  wire logic [color_readout_pkg::RESULT_W-1:0] red_value,
	input  wire logic [color_readout_pkg::RESULT_W-1:0] green_value,
	input  wire logic [color_readout_pkg::RESULT_W-1:0] blue_value,
	input  wire logic [color_readout_pkg::RESULT_W-1:0] low_threshold,
	input  wire logic [color_readout_pkg::RESULT_W-1:0] high_threshold,
	input  wire logic                                 irq_clear,
	output logic                                      clear_threshold_irq_flag,
	output logic                                      integration_done_flag
);
	import color_readout_pkg::*;

	// ---------------------------------------------------------------
	// result store
	// ---------------------------------------------------------------
	result_t result_q [0:CHANNELS-1];
	result_t result_d [0:CHANNELS-1];
	logic    irq_q;
	logic    irq_d;
	logic    done_q;
	logic    done_d;
	logic    out_of_range;

	assign result_d[0] = clear_value;
	assign result_d[1] = red_value;
	assign result_d[2] = green_value;
	assign result_d[3] = blue_value;

	// results move only on integration_end; reads in between see the last set
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			for (int i = 0; i < CHANNELS; i++) begin
				result_q[i] <= RESULT_RESET;
			end
		end else if (integration_end) begin
			for (int i = 0; i < CHANNELS; i++) begin
				result_q[i] <= result_d[i]; // R5
			end
		end
	end

	// ---------------------------------------------------------------
	// status flags
	// ---------------------------------------------------------------
	assign out_of_range = (clear_value < low_threshold) || (clear_value > high_threshold); // R4
	// new event wins over a clear in the same cycle
	assign irq_d  = (integration_end && out_of_range) || (irq_q && !irq_clear); // R4
	assign done_d = integration_end || done_q; // R3

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_q  <= 1'b0;
			done_q <= 1'b0;
		end else begin
			irq_q  <= irq_d;
			done_q <= done_d;
		end
	end

	// ---------------------------------------------------------------
	// flag outputs
	// ---------------------------------------------------------------
	// the pins show the same flops the status byte reads, but a status read
	// answers one cycle later, so its bits can lag the pins by one edge
	assign clear_threshold_irq_flag = irq_q; // R2
	assign integration_done_flag    = done_q; // R3

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	function automatic logic is_result(input logic [7:0] a);
		return (a >= ADDR_CLEAR_LOW) && (a <= ADDR_BLUE_HIGH);
	endfunction : is_result

	// channel of a result byte; outside the window the value is unused
	function automatic logic [1:0] chan_of(input logic [7:0] a);
		logic [1:0] c;
		c = 2'h0;
		case (a)
			ADDR_CLEAR_LOW, ADDR_CLEAR_HIGH: begin
				c = 2'h0;
			end
			ADDR_RED_LOW, ADDR_RED_HIGH: begin
				c = 2'h1;
			end
			ADDR_GREEN_LOW, ADDR_GREEN_HIGH: begin
				c = 2'h2;
			end
			ADDR_BLUE_LOW, ADDR_BLUE_HIGH: begin
				c = 2'h3;
			end
			default: begin
				c = 2'h0;
			end
		endcase
		return c;
	endfunction : chan_of

	// the odd addresses of the window are the high halves
	function automatic logic is_high(input logic [7:0] a);
		logic h;
		h = 1'b0;
		case (a)
			ADDR_CLEAR_HIGH, ADDR_RED_HIGH, ADDR_GREEN_HIGH, ADDR_BLUE_HIGH: begin
				h = 1'b1;
			end
			default: begin
				h = 1'b0;
			end
		endcase
		return h;
	endfunction : is_high

	// reserved bits stay zero whatever the flags do
	function automatic byte_t status_image(input logic irq, input logic done);
		byte_t s;
		s                  = STATUS_RESET;
		s[STATUS_IRQ_BIT]  = irq;
		s[STATUS_DONE_BIT] = done;
		return s;
	endfunction : status_image

	logic       hit_status;
	logic       hit_result;
	logic       low_hit;
	logic       read_high;
	byte_t      live_high;
	logic [1:0] chan;
	logic       high_sel;
	logic       low_read;
	byte_t      status_byte;
	byte_t      live_low;

	assign hit_status = (reg_addr == ADDR_DEVICE_STATUS);
	assign hit_result = is_result(reg_addr); // R6
	assign chan       = chan_of(reg_addr); // R6
	assign high_sel   = is_high(reg_addr); // R6
	assign low_hit    = hit_result && !high_sel;
	assign low_read   = reg_rd && low_hit;
	assign read_high  = reg_rd && hit_result && high_sel;
	assign live_low   = result_q[chan][7:0];

	assign status_byte = status_image(irq_q, done_q); // R2 R3

	// ---------------------------------------------------------------
	// shadow of high bytes
	// ---------------------------------------------------------------
	shadow_if sh ();

	// the byte captured is the one that stood at the low read's edge, so a
	// result landing on that same edge cannot split the pair
	assign live_high  = result_q[chan][15:8];
	assign sh.wr_en   = low_read; // R7
	assign sh.wr_chan = chan;
	assign sh.wr_data = live_high; // R7 R9
	assign sh.rd_chan = chan; // R8

	shadow_store u_shadow (
		.clock   (clock),
		.sys_rst (sys_rst),
		.port    (sh.store)
	);

	// ---------------------------------------------------------------
	// write strobe
	// ---------------------------------------------------------------
	// reg_wr and reg_wdata reach no register on purpose: every mapped
	// byte is read-only, so a stray host write cannot disturb a flag
	// or a result half-way through a word read

	// ---------------------------------------------------------------
	// read path: low/status answer one cycle later, high from shadow
	// ---------------------------------------------------------------
	logic       rd_q;
	logic       rd_high_q;
	byte_t      rdata_q;
	byte_t      rdata_d;

	assign rdata_d = hit_status ? status_byte : // R1
	                 low_hit ? live_low : UNMAPPED_READ;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rd_q      <= 1'b0;
			rd_high_q <= 1'b0;
			rdata_q   <= UNMAPPED_READ;
		end else begin
			rd_q      <= reg_rd;
			rd_high_q <= read_high;
			rdata_q   <= rdata_d;
		end
	end

	// shadow memory read lands in the same cycle as rdata_q
	assign reg_rdata  = rd_high_q ? sh.rd_data : rdata_q; // R8
	assign reg_rvalid = rd_q;

endmodule : color_result_status_readout

// ### logic/shadow_store.sv
module shadow_store (
	input wire logic clock,
	input wire logic sys_rst,
	shadow_if.store  port
);
	import color_readout_pkg::*;

	byte_t mem_q [0:CHANNELS-1];
	byte_t rd_q;

	// ---------------------------------------------------------------
	// storage, read data registered
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			for (int i = 0; i < CHANNELS; i++) begin
				mem_q[i] <= SHADOW_RESET;
			end
			rd_q <= SHADOW_RESET;
		end else begin
			if (port.wr_en) begin
				mem_q[port.wr_chan] <= port.wr_data;
			end
			rd_q <= mem_q[port.rd_chan];
		end
	end

	assign port.rd_data = rd_q;

endmodule : shadow_store

// ### pkg/color_readout_pkg.sv
package color_readout_pkg;

	localparam int          ADDR_W            = 8;
	localparam int          DATA_W            = 8;
	localparam int          RESULT_W          = 16;
	localparam int          CHANNELS          = 4;
	// register addresses
	localparam logic [7:0]  ADDR_DEVICE_STATUS = 8'h13;
	localparam logic [7:0]  ADDR_CLEAR_LOW     = 8'h14;
	localparam logic [7:0]  ADDR_CLEAR_HIGH    = 8'h15;
	localparam logic [7:0]  ADDR_RED_LOW       = 8'h16;
	localparam logic [7:0]  ADDR_RED_HIGH      = 8'h17;
	localparam logic [7:0]  ADDR_GREEN_LOW     = 8'h18;
	localparam logic [7:0]  ADDR_GREEN_HIGH    = 8'h19;
	localparam logic [7:0]  ADDR_BLUE_LOW      = 8'h1a;
	localparam logic [7:0]  ADDR_BLUE_HIGH     = 8'h1b;
	// status field positions
	localparam int          STATUS_IRQ_BIT     = 4;
	localparam int          STATUS_DONE_BIT    = 0;
	// reset values
	localparam logic [7:0]  STATUS_RESET       = 8'h00;
	localparam logic [15:0] RESULT_RESET       = 16'h0000;
	localparam logic [7:0]  SHADOW_RESET       = 8'h00;
	localparam logic [7:0]  UNMAPPED_READ      = 8'h00;

	typedef logic [RESULT_W-1:0] result_t;
	typedef logic [DATA_W-1:0]   byte_t;

endpackage : color_readout_pkg

// ### pkg/shadow_if.sv
interface shadow_if;
	import color_readout_pkg::*;

	logic [1:0] wr_chan;
	logic       wr_en;
	byte_t      wr_data;
	logic [1:0] rd_chan;
	byte_t      rd_data;

	modport owner (
		output wr_chan,
		output wr_en,
		output wr_data,
		output rd_chan,
		input  rd_data
	);
	modport store (
		input  wr_chan,
		input  wr_en,
		input  wr_data,
		input  rd_chan,
		output rd_data
	);
endinterface : shadow_if

// ### tb/host_model.sv
module host_model
	import color_readout_pkg::*;
(
	input wire logic  clock,
	input wire byte_t reg_rdata,
	input wire logic  reg_rvalid,
	output logic      reg_rd,
	output logic      reg_wr,
	output byte_t     reg_addr,
	output byte_t     reg_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	task access(input logic wr, input byte_t a, input byte_t wd, output byte_t d);
		@(posedge clock);
		#1;
		reg_rd = !wr;
		reg_wr = wr;
		reg_addr = a;
		reg_wdata = wd;
		@(posedge clock);
		#1;
		// a read with no answer hands back unknown so the caller's compare trips
		d = (wr || reg_rvalid) ? reg_rdata : 8'hxx;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		// released lines flip so a stale value never looks valid
		reg_addr = ~a;
		reg_wdata = ~wd;
	endtask : access
	task word_read(input byte_t a, output result_t w);
		access(1'b0, a, 8'h00, w[7:0]);
		access(1'b0, a + 8'h01, 8'h00, w[15:8]);
	endtask : word_read
endmodule : host_model

// ### tb/readout_chk.sv
module readout_chk
	import color_readout_pkg::*;
(
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic        integration_end,
	input wire logic [15:0] clear_value,
	input wire logic [15:0] low_threshold,
	input wire logic [15:0] high_threshold,
	input wire logic        irq_clear,
	input wire logic        clear_threshold_irq_flag,
	input wire logic        integration_done_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	wire oor = integration_end && (clear_value < low_threshold || clear_value > high_threshold);
	wire gap = reg_addr < 8'h13 || reg_addr > 8'h1b;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("no answer");
	a_stray_valid: assert property (!reg_rd |=> !reg_rvalid) else $error("stray valid");
	a_status_image: assert property (reg_rd && reg_addr == 8'h13 |=> reg_rdata ==
		{3'b0, $past(clear_threshold_irq_flag), 3'b0, $past(integration_done_flag)})
		else $error("bad status");
	a_irq_raise: assert property (oor |=> clear_threshold_irq_flag) else $error("no irq");
	a_irq_drop: assert property (irq_clear && !oor |=> !clear_threshold_irq_flag)
		else $error("irq kept");
	a_irq_quiet: assert property (!clear_threshold_irq_flag && !oor |=>
		!clear_threshold_irq_flag) else $error("stray irq");
	a_done_set: assert property (integration_end |=> integration_done_flag) else $error("no done");
	a_done_sticky: assert property (integration_done_flag |=> integration_done_flag)
		else $error("done lost");
	a_unmapped_zero: assert property (reg_rd && gap |=> reg_rdata == 8'h00) else $error("gap");
	cover property (reg_rd && reg_addr == 8'h15);
	cover property (oor);
	cover property (integration_end ##2 reg_rd);
endmodule : readout_chk

bind color_result_status_readout readout_chk u_readout_chk (.clock(clock), .sys_rst(sys_rst),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.integration_end(integration_end), .clear_value(clear_value), .irq_clear(irq_clear),
	.low_threshold(low_threshold), .high_threshold(high_threshold),
	.clear_threshold_irq_flag(clear_threshold_irq_flag),
	.integration_done_flag(integration_done_flag));

// ### tb/test_color_result_status_readout.sv
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
	$display("ERROR %0t got %h want %h", $time, a, b); end end
module test_color_result_status_readout;
	import color_readout_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic    clock = 1'b0, sys_rst = 1'b1, reg_rd, reg_wr, reg_rvalid, ie = 1'b0, clr = 1'b0;
	logic    irq, done;
	byte_t   reg_addr, reg_wdata, reg_rdata, d;
	result_t v[4] = '{default: 16'h0000}, w, old;
	int      failures = 0, samples_checked = 0;
	always #12.5 clock = ~clock;
	color_result_status_readout u_color_result_status_readout (.clock(clock), .sys_rst(sys_rst),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .integration_end(ie),
		.clear_value(v[0]), .red_value(v[1]), .green_value(v[2]), .blue_value(v[3]),
		.low_threshold(16'h0100), .high_threshold(16'hf000), .irq_clear(clr),
		.clear_threshold_irq_flag(irq), .integration_done_flag(done));
	host_model u_host_model (.clock(clock), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
	// strobe an integration end with new results, or an irq clear alone
	task strobe(input logic e, input result_t c);
		@(posedge clock);
		#1;
		if (e) v = '{c, c + 16'h0101, ~c, c ^ 16'h5a5a};
		ie = e;
		clr = !e;
		@(posedge clock);
		#1;
		ie = 1'b0;
		clr = 1'b0;
	endtask : strobe
	task rd(input byte_t a, input byte_t e);
		u_host_model.access(1'b0, a, 8'h00, d);
		`CHK(d, e)
	endtask : rd
	task tally_and_finish;
		if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (2) @(posedge clock);
		#1 sys_rst = 1'b0;
		`CHK({irq, done}, 2'b00)
		rd(ADDR_DEVICE_STATUS, STATUS_RESET);
		rd(ADDR_CLEAR_HIGH, SHADOW_RESET);
		strobe(1'b1, 16'h1234);
		for (int i = 0; i < CHANNELS; i++) begin
			u_host_model.word_read(ADDR_CLEAR_LOW + 8'(2 * i), w);
			`CHK(w, v[i])
		end
		rd(ADDR_DEVICE_STATUS, 8'h01);
		old = v[2];
		rd(ADDR_GREEN_LOW, old[7:0]);
		strobe(1'b1, 16'haabb);
		strobe(1'b1, 16'hccdd);
		rd(ADDR_GREEN_HIGH, old[15:8]);
		u_host_model.access(1'b1, ADDR_DEVICE_STATUS, 8'hff, d);
		rd(ADDR_DEVICE_STATUS, 8'h01);
		strobe(1'b1, 16'h0050);
		rd(ADDR_DEVICE_STATUS, 8'h11);
		strobe(1'b0, 16'h0000);
		rd(ADDR_DEVICE_STATUS, 8'h01);
		strobe(1'b1, 16'hf100);
		rd(ADDR_DEVICE_STATUS, 8'h11);
		`CHK({irq, done}, 2'b11)
		rd(8'h1c, UNMAPPED_READ);
		// second reset mid-run: flags, results and shadows all drop back
		@(posedge clock);
		#1 sys_rst = 1'b1;
		repeat (2) @(posedge clock);
		#1 sys_rst = 1'b0;
		`CHK({irq, done}, 2'b00)
		rd(ADDR_DEVICE_STATUS, STATUS_RESET);
		rd(ADDR_GREEN_HIGH, SHADOW_RESET);
		rd(ADDR_BLUE_LOW, RESULT_RESET[7:0]);
		tally_and_finish;
	end
endmodule : test_color_result_status_readout
